// ### logic/hsp_pkg.sv
// Purpose: Shared constants for the serial host port with break reset
// Assumes: 100 MHz clock, 8 data bits per character
// Notes:   Both ends of the link import this package
package hsp_pkg;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned DATA_BITS      = 8;
   localparam int unsigned BAUD_MIN       = 1200;
   localparam int unsigned BAUD_MAX       = 1_500_000;
   // Default divider: 115200 baud, clocks per bit
   localparam int unsigned BAUD_DEFAULT   = 115200;
   localparam int unsigned DIV_DEFAULT    = CLK_HZ / BAUD_DEFAULT;
   localparam int unsigned DIV_W          = 17;
   // Break threshold in microseconds, and in clock cycles
   localparam int unsigned BRK_US         = 10_000;
   localparam int unsigned BRK_CYCLES     = BRK_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BRK_W          = 32;
   // Receive buffer depth, and fill level at which request is withdrawn
   localparam int unsigned RX_DEPTH       = 4;
   localparam int unsigned RX_NEAR_FULL   = 3;
   // Parity selection codes
   localparam logic [1:0]  PAR_NONE       = 2'h0;
   localparam logic [1:0]  PAR_ODD        = 2'h1;
   localparam logic [1:0]  PAR_EVEN       = 2'h2;
   typedef struct packed {
      logic [DIV_W-1:0] div;     // Clocks per bit
      logic [1:0]       parity;  // PAR_* code
      logic             stop2;   // Two stop bits
      logic             flow_en; // Hardware handshaking
   } hsp_cfg_t;
endpackage

// ### logic/hsp_link_if.sv
// Purpose: Serial link between the module port and the host port
// Assumes: All lines are plain push-pull levels
// Notes:   Handshake lines are active low
`timescale 1ns/1ps
interface hsp_link_if;
   logic dev_txd;      // Module to host data
   logic host_txd;     // Host to module data
   logic dev_rts_n;    // Module may receive when low
   logic host_rts_n;   // Host may receive when low
   modport dev  (output dev_txd, input host_txd,
                 output dev_rts_n, input host_rts_n);
   modport host (input dev_txd, output host_txd,
                 input dev_rts_n, output host_rts_n);
endinterface

// ### logic/hsp_host_end.sv
// Purpose: Host end of the serial link
// Assumes: Same character format and divider as the module end
// Notes:   Can hold its transmit line low to reset the module
`timescale 1ns/1ps
module hsp_host_end
   import hsp_pkg::*;
(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_b_i,
   input  wire logic              ce_i,
   // Configuration
   input  wire hsp_pkg::hsp_cfg_t cfg_i,
   // Transmit side
   input  wire logic              tx_valid_i,
   input  wire logic [7:0]        tx_data_i,
   output logic                   tx_ready_o,
   input  wire logic              brk_send_i,
   // Receive side
   output logic                   rx_valid_o,
   output logic [7:0]             rx_data_o,
   output logic                   rx_err_o,
   input  wire logic              rx_hold_i,
   // Link
   hsp_link_if.host               link
);
   import hsp_pkg::*;

   typedef enum logic [1:0] {HT_IDLE, HT_SHIFT} hsp_hst_t;
   hsp_hst_t         tx_st;
   logic [11:0]      tx_sh;
   logic [3:0]       tx_left;
   logic [DIV_W-1:0] tx_cnt;
   logic             txd;
   logic [DIV_W-1:0] rx_cnt;
   logic [3:0]       rx_bit;
   logic [9:0]       rx_sh;
   logic             rx_busy;

   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] p);
      par_bit = (p == PAR_ODD) ? ~^d : ^d;
   endfunction

   assign tx_ready_o = (tx_st == HT_IDLE) && !brk_send_i
                       && (!cfg_i.flow_en || !link.dev_rts_n);
   assign link.host_txd   = txd && !brk_send_i;
   assign link.host_rts_n = rx_hold_i;

   // Host transmitter: start, 8 data lsb first, parity, stops
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_st   <= HT_IDLE;
         tx_sh   <= 12'hfff;
         tx_left <= 4'h0;
         tx_cnt  <= '0;
         txd     <= 1'b1;
      end else if (ce_i) begin
         case (tx_st)
            HT_IDLE: begin
               txd <= 1'b1;
               if (tx_valid_i && tx_ready_o) begin
                  // No parity: a stop bit takes the parity slot
                  tx_sh   <= (cfg_i.parity != PAR_NONE)
                     ? {2'b11, par_bit(tx_data_i, cfg_i.parity),
                        tx_data_i, 1'b0}
                     : {3'b111, tx_data_i, 1'b0};
                  tx_left <= 4'd10 + ((cfg_i.parity != PAR_NONE) ? 4'd1 : 4'd0)
                             + (cfg_i.stop2 ? 4'd1 : 4'd0);
                  tx_cnt  <= '0;
                  tx_st   <= HT_SHIFT;
               end
            end
            HT_SHIFT: begin
               txd <= tx_sh[0];
               if (tx_cnt == cfg_i.div - 1'b1) begin
                  tx_cnt  <= '0;
                  tx_left <= tx_left - 4'd1;
                  tx_sh   <= {1'b1, tx_sh[11:1]};
                  if (tx_left == 4'd1) begin
                     tx_st <= HT_IDLE;
                  end
               end else begin
                  tx_cnt <= tx_cnt + 1'b1;
               end
            end
            default: tx_st <= HT_IDLE;
         endcase
      end
   end

   // Host receiver: mid-bit sampling, parity and stop check
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_busy    <= 1'b0;
         rx_cnt     <= '0;
         rx_bit     <= 4'h0;
         rx_sh      <= 10'h0;
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
         rx_err_o   <= 1'b0;
      end else if (ce_i) begin
         rx_valid_o <= 1'b0;
         if (!rx_busy) begin
            if (!link.dev_txd) begin
               rx_busy <= 1'b1;
               rx_cnt  <= '0;
               rx_bit  <= 4'h0;
            end
         end else if (rx_cnt == (rx_bit == 4'h0 ? cfg_i.div >> 1
                                                : cfg_i.div - 1'b1)) begin
            rx_cnt <= '0;
            rx_bit <= rx_bit + 4'd1;
            rx_sh  <= {link.dev_txd, rx_sh[9:1]};
            if (rx_bit == 4'd9 + ((cfg_i.parity != PAR_NONE) ? 4'd1 : 4'd0))
            begin
               rx_busy    <= 1'b0;
               rx_valid_o <= 1'b1;
               // With parity the last shifted sample is the parity bit
               if (cfg_i.parity != PAR_NONE) begin
                  rx_data_o <= rx_sh[8:1];
                  rx_err_o  <= !link.dev_txd
                     || par_bit(rx_sh[8:1], cfg_i.parity) != rx_sh[9];
               end else begin
                  rx_data_o <= rx_sh[9:2];
                  rx_err_o  <= !link.dev_txd;
               end
            end
         end else begin
            rx_cnt <= rx_cnt + 1'b1;
         end
      end
   end
endmodule

// ### logic/hsp_dev_end.sv
// Purpose: Module end of the serial host port with break reset
// Assumes: Inputs synchronous to clock_i, shared format with host
// Notes:   Long low on the receive line raises a module reset pulse
`timescale 1ns/1ps
module hsp_dev_end
   import hsp_pkg::*;
#(
   parameter int unsigned BRK_LIMIT = BRK_CYCLES
)(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_b_i,
   input  wire logic              ce_i,
   // Configuration
   input  wire hsp_pkg::hsp_cfg_t cfg_i,
   // Transmit side
   input  wire logic              tx_valid_i,
   input  wire logic [7:0]        tx_data_i,
   output logic                   tx_ready_o,
   input  wire logic              brk_send_i,
   // Receive side
   output logic                   rx_valid_o,
   output logic [7:0]             rx_data_o,
   output logic                   rx_err_o,
   input  wire logic              rx_take_i,
   // Break detection
   output logic                   brk_reset_o,
   // Link
   hsp_link_if.dev                link
);
   import hsp_pkg::*;

   // Threshold below two cycles cannot tell a break from a bit
   if (BRK_LIMIT < 2) begin : g_brk_limit_chk
      $error("BRK_LIMIT too small");
   end

   typedef enum logic [1:0] {DT_IDLE, DT_SHIFT} hsp_dst_t;
   hsp_dst_t         tx_st;
   logic [11:0]      tx_sh;
   logic [3:0]       tx_left;
   logic [DIV_W-1:0] tx_cnt;
   logic             txd;
   logic [DIV_W-1:0] rx_cnt;
   logic [3:0]       rx_bit;
   logic [9:0]       rx_sh;
   logic             rx_busy;
   logic [BRK_W-1:0] low_cnt;
   logic             brk_seen;
   logic [7:0]       rx_mem [RX_DEPTH];
   logic [1:0]       wr_ptr;
   logic [1:0]       rd_ptr;
   logic [2:0]       fill;
   logic             push;
   logic             pop;
   logic [7:0]       rx_byte;
   logic             rx_bad;

   // Parity of a character for the selected sense
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] p);
      par_bit = (p == PAR_ODD) ? ~^d : ^d;
   endfunction

   // Frame length in bit times after the start bit
   function automatic logic [3:0] frame_bits(input hsp_cfg_t c);
      frame_bits = 4'd9 + ((c.parity != PAR_NONE) ? 4'd1 : 4'd0)
                   + (c.stop2 ? 4'd1 : 4'd0);
   endfunction

   // Ready when idle, not breaking, and clear low if flow on
   assign tx_ready_o = (tx_st == DT_IDLE) && !brk_send_i
                       && (!cfg_i.flow_en || !link.host_rts_n);
   assign link.dev_txd = txd && !brk_send_i;
   assign link.dev_rts_n = cfg_i.flow_en
                           && (fill >= 3'(RX_NEAR_FULL));

   // Transmitter shift register and bit timer
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_st   <= DT_IDLE;
         tx_sh   <= 12'hfff;
         tx_left <= 4'h0;
         tx_cnt  <= '0;
         txd     <= 1'b1;
      end else if (ce_i) begin
         case (tx_st)
            DT_IDLE: begin
               txd <= 1'b1;
               if (tx_valid_i && tx_ready_o) begin
                  // Parity slot skipped by packing stop in its place
                  tx_sh   <= (cfg_i.parity != PAR_NONE)
                     ? {2'b11, par_bit(tx_data_i, cfg_i.parity),
                        tx_data_i, 1'b0}
                     : {3'b111, tx_data_i, 1'b0};
                  tx_left <= frame_bits(cfg_i) + 4'd1;
                  tx_cnt  <= '0;
                  tx_st   <= DT_SHIFT;
               end
            end
            DT_SHIFT: begin
               txd <= tx_sh[0];
               if (tx_cnt == cfg_i.div - 1'b1) begin
                  tx_cnt  <= '0;
                  tx_left <= tx_left - 4'd1;
                  tx_sh   <= {1'b1, tx_sh[11:1]};
                  if (tx_left == 4'd1) begin
                     tx_st <= DT_IDLE;
                  end
               end else begin
                  tx_cnt <= tx_cnt + 1'b1;
               end
            end
            default: tx_st <= DT_IDLE;
         endcase
      end
   end

   // Receiver: start detect, mid-bit sampling, checks
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_busy <= 1'b0;
         rx_cnt  <= '0;
         rx_bit  <= 4'h0;
         rx_sh   <= 10'h0;
         rx_byte <= 8'h00;
         rx_bad  <= 1'b0;
         push    <= 1'b0;
      end else if (ce_i) begin
         push <= 1'b0;
         if (!rx_busy) begin
            if (!link.host_txd && !brk_seen) begin
               rx_busy <= 1'b1;
               rx_cnt  <= '0;
               rx_bit  <= 4'h0;
            end
         end else if (rx_cnt == (rx_bit == 4'h0 ? cfg_i.div >> 1
                                                : cfg_i.div - 1'b1)) begin
            rx_cnt <= '0;
            rx_bit <= rx_bit + 4'd1;
            rx_sh  <= {link.host_txd, rx_sh[9:1]};
            if (rx_bit == frame_bits(cfg_i) - (cfg_i.stop2 ? 4'd1 : 4'd0))
            begin
               // Stop bit sampled; second stop not checked
               rx_busy <= 1'b0;
               push    <= 1'b1;
               // With parity the last shifted sample is the parity bit
               if (cfg_i.parity != PAR_NONE) begin
                  rx_byte <= rx_sh[8:1];
                  rx_bad  <= !link.host_txd
                     || par_bit(rx_sh[8:1], cfg_i.parity) != rx_sh[9];
               end else begin
                  rx_byte <= rx_sh[9:2];
                  rx_bad  <= !link.host_txd;
               end
            end
         end else begin
            rx_cnt <= rx_cnt + 1'b1;
         end
      end
   end

   // Receive buffer; overrun drops the new character
   assign pop = rx_take_i && (fill != 3'h0);
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr <= 2'h0;
         rd_ptr <= 2'h0;
         fill   <= 3'h0;
      end else if (ce_i) begin
         if (push && fill != 3'(RX_DEPTH)) begin
            wr_ptr <= wr_ptr + 2'h1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 2'h1;
         end
         fill <= fill + ((push && fill != 3'(RX_DEPTH)) ? 3'h1 : 3'h0)
                 - (pop ? 3'h1 : 3'h0);
      end
   end

   // Buffer storage; no reset, the valid flag gates its contents
   always_ff @(posedge clock_i) begin
      if (ce_i && push && fill != 3'(RX_DEPTH)) begin
         rx_mem[wr_ptr] <= rx_byte;
      end
   end

   // Head of buffer presented from flip-flops
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
         rx_err_o   <= 1'b0;
      end else if (ce_i) begin
         rx_valid_o <= (fill != 3'h0) && !pop;
         rx_data_o  <= rx_mem[rd_ptr];
         if (push) begin
            rx_err_o <= rx_bad;
         end
      end
   end

   // Break: count continuous low, pulse reset past threshold
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         low_cnt     <= '0;
         brk_seen    <= 1'b0;
         brk_reset_o <= 1'b0;
      end else if (ce_i) begin
         brk_reset_o <= 1'b0;
         if (link.host_txd) begin
            low_cnt  <= '0;
            brk_seen <= 1'b0;
         end else if (!brk_seen) begin
            low_cnt <= low_cnt + 1'b1;
            if (low_cnt >= BRK_W'(BRK_LIMIT)) begin
               brk_seen    <= 1'b1;
               brk_reset_o <= 1'b1;
            end
         end
      end
   end
endmodule

// ### verification/hsp_link_assertions.sv
// Purpose: Link checks for the serial host port pair
// Assumes: Breaks are only sent while the line is idle
// Notes:   Frame timing follows the module end configuration
`timescale 1ns/1ps
module hsp_link_assertions
   import hsp_pkg::*;
#(
   parameter int unsigned BRK_LIMIT = 200
)(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_b_i,
   // Link lines
   input  wire logic              dev_txd,
   input  wire logic              host_txd,
   input  wire logic              dev_rts_n,
   input  wire logic              host_rts_n,
   // Context
   input  wire hsp_pkg::hsp_cfg_t cfg_d,
   input  wire logic              d_brk,
   input  wire logic              brk_rst
);
   import hsp_pkg::*;

   logic [16:0] d_run, h_run, d_cnt, h_cnt, span, flen;
   logic [31:0] low_run;
   logic        d_prev, h_prev, d_start, h_start;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   // Stop span, frame length and start detection
   assign span    = cfg_d.stop2 ? 17'(cfg_d.div * 2) : cfg_d.div;
   assign flen    = 17'(cfg_d.div * ((cfg_d.parity != PAR_NONE) ? 10 : 9))
                    + span;
   assign d_start = d_prev && !dev_txd && (d_cnt == '0);
   assign h_start = h_prev && !host_txd && (h_cnt == '0);

   // Line history and level run lengths
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         d_prev <= 1'b1;
         h_prev <= 1'b1;
         d_run  <= 17'h100;
         h_run  <= 17'h100;
      end else begin
         d_prev <= dev_txd;
         h_prev <= host_txd;
         d_run  <= (dev_txd != d_prev) ? 17'h1 : d_run + 17'h1;
         h_run  <= (host_txd != h_prev) ? 17'h1 : h_run + 17'h1;
      end
   end

   // Frame position counters and host low run
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         d_cnt   <= '0;
         h_cnt   <= '0;
         low_run <= '0;
      end else begin
         d_cnt   <= d_start ? flen - 17'h1 : d_cnt - 17'(d_cnt != '0);
         h_cnt   <= h_start ? flen - 17'h1 : h_cnt - 17'(h_cnt != '0);
         low_run <= host_txd ? 32'h0 : low_run + 32'h1;
      end
   end

   sequence s_brk_quiet;
      !brk_rst [*8];
   endsequence

   a_dev_bit_width: assert property (
      (dev_txd != d_prev) |-> (d_run >= cfg_d.div))
      else $error("module line bit shorter than divider");
   a_host_bit_width: assert property (
      (host_txd != h_prev) |-> (h_run >= cfg_d.div))
      else $error("host line bit shorter than divider");
   a_brk_needs_low: assert property (
      brk_rst |-> (low_run > BRK_LIMIT))
      else $error("reset pulse without a long enough low");
   a_brk_in_time: assert property (
      (low_run == BRK_LIMIT + 1) |-> ##[0:8] brk_rst)
      else $error("long low gave no reset pulse");
   a_brk_single: assert property (
      brk_rst |-> ##1 s_brk_quiet)
      else $error("reset pulse repeated");
   a_rts_flow_off: assert property (
      !cfg_d.flow_en && !$past(cfg_d.flow_en) |-> !dev_rts_n)
      else $error("request withdrawn with flow control off");
   a_host_gated: assert property (
      h_start && cfg_d.flow_en |-> !($past(dev_rts_n) && $past(dev_rts_n, 2)))
      else $error("host started while module request high");
   a_dev_stop_high: assert property (
      d_cnt >= 17'h2 && d_cnt < span && !d_brk |-> dev_txd)
      else $error("module stop bit not high");
endmodule

// ### verification/tb_top.sv
// Purpose: Self-checking bench for both ends of the serial host port
// Assumes: One shared clock, break limit shortened to 200 cycles
// Notes:   Frames are checked on the wire and at both user sides
`timescale 1ns/1ps
module tb_top;
   import hsp_pkg::*;
   localparam int unsigned DIV = 20;
   localparam int unsigned BRK = 200;
   logic       clock_i, rst_b_i, ce_i, d_tx_valid, d_tx_ready, d_brk;
   logic       d_rx_valid, d_rx_err, d_take, brk_rst, h_tx_valid, h_lerr;
   logic       h_tx_ready, h_brk, h_rx_valid, h_rx_err, h_hold;
   logic [7:0] d_tx_data, d_rx_data, h_tx_data, h_rx_data, h_last;
   hsp_cfg_t   cfg_d, cfg_h;
   int         n_mismatch, num_checks, n_hrx, n_brk, p, s;

   hsp_link_if lnk ();
   hsp_dev_end #(.BRK_LIMIT(BRK)) i_hsp_dev_end (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cfg_i(cfg_d),
      .tx_valid_i(d_tx_valid), .tx_data_i(d_tx_data),
      .tx_ready_o(d_tx_ready), .brk_send_i(d_brk), .rx_valid_o(d_rx_valid),
      .rx_data_o(d_rx_data), .rx_err_o(d_rx_err), .rx_take_i(d_take),
      .brk_reset_o(brk_rst), .link(lnk));
   hsp_host_end i_hsp_host_end (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cfg_i(cfg_h),
      .tx_valid_i(h_tx_valid), .tx_data_i(h_tx_data),
      .tx_ready_o(h_tx_ready), .brk_send_i(h_brk), .rx_valid_o(h_rx_valid),
      .rx_data_o(h_rx_data), .rx_err_o(h_rx_err), .rx_hold_i(h_hold),
      .link(lnk));
   hsp_link_assertions #(.BRK_LIMIT(BRK)) i_hsp_link_assertions (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .dev_txd(lnk.dev_txd),
      .host_txd(lnk.host_txd), .dev_rts_n(lnk.dev_rts_n),
      .host_rts_n(lnk.host_rts_n), .cfg_d(cfg_d), .d_brk(d_brk),
      .brk_rst(brk_rst));

   // Clock generator
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Host receive pulses and module reset pulses
   always @(posedge clock_i) begin
      if (h_rx_valid === 1'b1) begin
         n_hrx  <= n_hrx + 1;
         h_last <= h_rx_data;
         h_lerr <= h_rx_err;
      end
      if (brk_rst === 1'b1) begin
         n_brk <= n_brk + 1;
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t %s got %b exp %b", $time, m, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Bounded wait for a level sampled high at a clock edge
   task automatic wait_hi(ref logic sig);
      int i;
      for (i = 0; i < 5000 && sig !== 1'b1; i++) begin
         @(posedge clock_i);
      end
      if (sig !== 1'b1) begin
         n_mismatch++;
         $display("FAIL %0t wait timed out", $time);
         finish_test();
      end
   endtask

   task automatic pop();
      d_take <= 1'b1;
      @(posedge clock_i);
      d_take <= 1'b0;
      @(posedge clock_i);
   endtask

   // Empty the module buffer; one edge between checks of the flag, three after a pop
   task automatic drain();
      repeat (16) begin
         @(posedge clock_i);
         if (d_rx_valid === 1'b1) begin
            pop();
         end
      end
   endtask

   task automatic take_chk(input logic [7:0] d, input logic perr);
      wait_hi(d_rx_valid);
      chk_byte(d_rx_data, d, "module rx data");
      chk_bit(d_rx_err, perr, "module rx error");
      pop();
   endtask

   task automatic set_cfg(input logic [1:0] par, input logic two, fl);
      @(posedge clock_i);
      cfg_d <= '{div: 17'(DIV), parity: par, stop2: two, flow_en: fl};
      cfg_h <= '{div: 17'(DIV), parity: par, stop2: two, flow_en: fl};
      repeat (2) @(posedge clock_i);
   endtask

   task automatic h2d(input logic [7:0] d, input logic take, perr);
      @(posedge clock_i);
      h_tx_valid <= 1'b1;
      h_tx_data  <= d;
      @(posedge clock_i);
      wait_hi(h_tx_ready);
      h_tx_valid <= 1'b0;
      if (take) begin
         take_chk(d, perr);
      end
   endtask

   // Module sends one character, sampled mid-bit on the wire
   task automatic d2h(input logic [7:0] d);
      logic [12:0] fr;
      int          n, c0;
      fr = {3'b111, (cfg_d.parity == PAR_ODD) ? ~^d : ^d, d, 1'b0};
      if (cfg_d.parity == PAR_NONE) begin
         fr[9] = 1'b1;
      end
      n  = ((cfg_d.parity == PAR_NONE) ? 10 : 11) + int'(cfg_d.stop2);
      c0 = n_hrx;
      @(posedge clock_i);
      d_tx_valid <= 1'b1;
      d_tx_data  <= d;
      @(posedge clock_i);
      wait_hi(d_tx_ready);
      d_tx_valid <= 1'b0;
      repeat (DIV / 2 + 1) @(posedge clock_i);
      for (int k = 0; k < n; k++) begin
         chk_bit(lnk.dev_txd, fr[k], "wire bit");
         repeat (DIV) @(posedge clock_i);
      end
      chk_byte(8'(n_hrx - c0), 8'h1, "host rx count");
      chk_byte(h_last, d, "host rx data");
      chk_bit(h_lerr, 1'b0, "host rx error");
   endtask

   // Main sequence
   initial begin
      {rst_b_i, d_tx_valid, d_tx_data, d_brk, d_take} = '0;
      {h_tx_valid, h_tx_data, h_brk, h_hold} = '0;
      {n_mismatch, num_checks, n_hrx, n_brk} = '0;
      ce_i  = 1'b1;
      cfg_d = '{div: 17'(DIV), parity: PAR_NONE, stop2: 1'b0, flow_en: 1'b0};
      cfg_h = cfg_d;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      for (p = 0; p < 3; p++) begin
         for (s = 0; s < 2; s++) begin
            set_cfg(2'(p), s[0], 1'b0);
            h2d(8'ha5, 1'b1, 1'b0);
            d2h(8'h3c ^ 8'(p + s));
         end
      end
      set_cfg(PAR_EVEN, 1'b0, 1'b0);
      cfg_h.parity <= PAR_ODD;
      h2d(8'h5a, 1'b1, 1'b1);
      set_cfg(PAR_NONE, 1'b0, 1'b1);
      h_hold <= 1'b1;
      repeat (4) @(posedge clock_i);
      chk_bit(d_tx_ready, 1'b0, "tx gated");
      h_hold <= 1'b0;
      repeat (4) @(posedge clock_i);
      chk_bit(d_tx_ready, 1'b1, "tx open");
      d2h(8'he7);
      repeat (3) h2d(8'h11, 1'b0, 1'b0);
      repeat (12 * DIV) @(posedge clock_i);
      chk_bit(lnk.dev_rts_n, 1'b1, "request withdrawn");
      chk_bit(h_tx_ready, 1'b0, "host gated");
      repeat (3) take_chk(8'h11, 1'b0);
      repeat (4) @(posedge clock_i);
      chk_bit(lnk.dev_rts_n, 1'b0, "request given");
      set_cfg(PAR_NONE, 1'b0, 1'b0);
      h_hold <= 1'b1;
      repeat (4) @(posedge clock_i);
      chk_bit(d_tx_ready, 1'b1, "clear ignored");
      d2h(8'h6e);
      h_hold <= 1'b0;
      h_brk  <= 1'b1;
      repeat (BRK - 50) @(posedge clock_i);
      h_brk <= 1'b0;
      // Let any frame started by the low run finish first
      repeat (12 * DIV) @(posedge clock_i);
      chk_byte(8'(n_brk), 8'h0, "short low");
      drain();
      h_brk <= 1'b1;
      repeat (BRK + 100) @(posedge clock_i);
      h_brk <= 1'b0;
      repeat (12 * DIV) @(posedge clock_i);
      chk_byte(8'(n_brk), 8'h1, "break reset");
      drain();
      h2d(8'hc3, 1'b1, 1'b0);
      d_brk <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk_bit(lnk.dev_txd, 1'b0, "break out");
      chk_bit(d_tx_ready, 1'b0, "break blocks tx");
      repeat (BRK + 50) @(posedge clock_i);
      d_brk <= 1'b0;
      // Host receiver must finish the frames the break started
      repeat (12 * DIV) @(posedge clock_i);
      d2h(8'h96);
      finish_test();
   end
endmodule
